// [include/pdb_pkg.sv]
// constants, types and register map of the divider and bypass config bank
`default_nettype none
package pdb_pkg;

   // serial frame layout: rw flag, 7-bit address, 8-bit data, msb first
   localparam int unsigned FRAME_BITS  = 16;
   localparam int unsigned HEADER_BITS = 8;
   localparam int unsigned CNT_W       = 5;
   localparam int unsigned ADDR_W      = 7;
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned RW_POS      = 7;

   localparam logic [CNT_W-1:0] CNT_HEADER = 5'h08;
   localparam logic [CNT_W-1:0] CNT_FRAME  = 5'h10;
   localparam logic [CNT_W-1:0] CNT_LAST_H = 5'h07;
   localparam logic [CNT_W-1:0] CNT_LAST_F = 5'h0f;

   // register addresses
   localparam logic [ADDR_W-1:0] ADDR_FEEDBACK_EXT  = 7'h03;
   localparam logic [ADDR_W-1:0] ADDR_LOOP_BYPASS   = 7'h0a;
   localparam logic [ADDR_W-1:0] ADDR_POLARITY_PUMP = 7'h10;
   localparam logic [ADDR_W-1:0] ADDR_OSC_OFFSET    = 7'h11;
   localparam logic [ADDR_W-1:0] ADDR_OSC_AMP_PUMP  = 7'h12;
   localparam logic [ADDR_W-1:0] ADDR_PRESCALE_LO   = 7'h20;
   localparam logic [ADDR_W-1:0] ADDR_PRESCALE_HI   = 7'h21;
   localparam logic [ADDR_W-1:0] ADDR_SECOND_STAGE  = 7'h22;

   // writable bit masks; other bits are reserved and read as zero
   localparam logic [DATA_W-1:0] MASK_FEEDBACK_EXT  = 8'h81;
   localparam logic [DATA_W-1:0] MASK_LOOP_BYPASS   = 8'h01;
   localparam logic [DATA_W-1:0] MASK_POLARITY_PUMP = 8'hdf;
   localparam logic [DATA_W-1:0] MASK_OSC_OFFSET    = 8'hff;
   localparam logic [DATA_W-1:0] MASK_OSC_AMP_PUMP  = 8'h7f;
   localparam logic [DATA_W-1:0] MASK_PRESCALE_HI   = 8'h01;
   localparam logic [DATA_W-1:0] MASK_SECOND_STAGE  = 8'hff;

   // reset values
   localparam logic [DATA_W-1:0] RST_FEEDBACK_EXT  = 8'h00;
   localparam logic [DATA_W-1:0] RST_LOOP_BYPASS   = 8'h00;
   localparam logic [DATA_W-1:0] RST_POLARITY_PUMP = 8'h58;
   localparam logic [DATA_W-1:0] RST_OSC_OFFSET    = 8'h00;
   localparam logic [DATA_W-1:0] RST_OSC_AMP_PUMP  = 8'h00;
   localparam logic [8:0]        RST_PRESCALE      = 9'h018;
   localparam logic [8:0]        PRESCALE_MIN      = 9'h008;
   localparam logic [DATA_W-1:0] RST_SECOND_STAGE  = 8'h00;
   localparam logic [5:0]        PREDIV_BYPASS     = 6'h00;

   // field positions
   localparam int unsigned FEEDBACK_EXT_POS  = 0;
   localparam int unsigned FEEDBACK_B8_POS   = 7;
   localparam int unsigned LOOP_BYPASS_POS   = 0;
   localparam int unsigned POLARITY_POS      = 7;
   localparam int unsigned FORCE_MID_POS     = 6;
   localparam int unsigned PRESCALE_HI_POS   = 0;
   localparam int unsigned DOUBLER_POS       = 6;
   localparam int unsigned OSC_CHOICE_POS    = 7;
   localparam int unsigned OSC_POWER_POS     = 7;
   localparam int unsigned OSC_FORMAT_POS    = 6;
   localparam int unsigned OFFSET_EN_POS     = 5;
   localparam int unsigned AMP_LSB           = 5;
   localparam int unsigned AMP_MSB           = 6;
   localparam int unsigned PUMP_LSB          = 0;
   localparam int unsigned PUMP_MSB          = 4;
   localparam int unsigned PREDIV_LSB        = 0;
   localparam int unsigned PREDIV_MSB        = 5;

   typedef struct packed {
      logic              valid;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } pdb_wr_t;

   typedef struct packed {
      logic [8:0] prescale_ratio;
      logic [5:0] reference_prediv;
      logic       prediv_bypassed;
      logic       doubler_select;
      logic       oscillator_choice;
      logic       feedback_extension;
      logic       feedback_div_b_msb;
      logic       jitter_loop_bypass;
      logic       tuning_polarity;
      logic       force_mid_tuning;
      logic [4:0] first_loop_pump_current;
      logic       osc_output_power;
      logic       osc_output_format;
      logic       phase_offset_enable;
      logic [4:0] phase_offset;
      logic [1:0] osc_output_amplitude;
      logic [4:0] second_loop_pump_current;
   } pdb_cfg_t;

endpackage : pdb_pkg
`default_nettype wire

// [logic/pdb_spi_port.sv]
// three-wire serial configuration port, oversampled on the system clock
`default_nettype none
module pdb_spi_port
(
   input  wire logic                        clk_sys,
   input  wire logic                        rst,
   input  wire logic                        spi_sclk,
   input  wire logic                        spi_cs_n,
   input  wire logic                        spi_sdio_i,
   output logic                             spi_sdio_o,
   output logic                             spi_sdio_oe_n,
   output logic [pdb_pkg::ADDR_W-1:0]       rd_addr,
   input  wire logic [pdb_pkg::DATA_W-1:0]  rd_data,
   output pdb_pkg::pdb_wr_t                 wr
);

   logic [2:0]                    sclk_s_r;
   logic [1:0]                    cs_s_r;
   logic [1:0]                    sdi_s_r;
   logic [pdb_pkg::CNT_W-1:0]     cnt_r;
   logic [pdb_pkg::DATA_W-1:0]    shin_r;
   logic [pdb_pkg::DATA_W-1:0]    shout_r;
   logic [pdb_pkg::ADDR_W-1:0]    addr_r;
   logic                          read_r;
   logic                          load_r;
   logic                          sdo_r;
   logic                          oe_n_r;
   pdb_pkg::pdb_wr_t              wr_r;
   logic                          rise;
   logic                          fall;
   logic                          sel;
   logic [pdb_pkg::DATA_W-1:0]    shin_nxt;

   // first stage of each synchroniser feeds only the second
   always_ff @(posedge clk_sys or posedge rst)
      if (rst)
      begin
         sclk_s_r <= 3'h0;
         cs_s_r   <= 2'h3;
         sdi_s_r  <= 2'h0;
      end
      else
      begin
         sclk_s_r <= {sclk_s_r[1:0], spi_sclk};
         cs_s_r   <= {cs_s_r[0], spi_cs_n};
         sdi_s_r  <= {sdi_s_r[0], spi_sdio_i};
      end

   assign rise     = sclk_s_r[1] & ~sclk_s_r[2];
   assign fall     = ~sclk_s_r[1] & sclk_s_r[2];
   assign sel      = ~cs_s_r[1];
   assign shin_nxt = {shin_r[pdb_pkg::DATA_W-2:0], sdi_s_r[1]};

   always_ff @(posedge clk_sys or posedge rst)
      if (rst)
      begin
         cnt_r  <= '0;
         shin_r <= '0;
         addr_r <= '0;
         read_r <= 1'b0;
      end
      else if (!sel)
      begin
         cnt_r  <= '0;
         read_r <= 1'b0;
      end
      else if (rise && cnt_r != pdb_pkg::CNT_FRAME)
      begin
         cnt_r  <= cnt_r + 5'h01;
         shin_r <= shin_nxt;
         if (cnt_r == pdb_pkg::CNT_LAST_H)
         begin
            read_r <= shin_nxt[pdb_pkg::RW_POS];
            addr_r <= shin_nxt[pdb_pkg::ADDR_W-1:0];
         end
      end

   // one-cycle write strobe after the last data bit of a write frame
   always_ff @(posedge clk_sys or posedge rst)
      if (rst)
         wr_r <= '0;
      else
      begin
         wr_r.valid <= sel && rise && !read_r &&
                       cnt_r == pdb_pkg::CNT_LAST_F;
         wr_r.addr  <= addr_r;
         wr_r.data  <= shin_nxt;
      end

   // read data is captured once the header is in; sclk must stay high
   // for at least two system clocks so it is ready for the next fall
   always_ff @(posedge clk_sys or posedge rst)
      if (rst)
      begin
         load_r  <= 1'b0;
         shout_r <= '0;
         sdo_r   <= 1'b0;
         oe_n_r  <= 1'b1;
      end
      else
      begin
         load_r <= sel && rise && cnt_r == pdb_pkg::CNT_LAST_H;
         if (!sel)
            oe_n_r <= 1'b1;
         else if (load_r)
            shout_r <= rd_data;
         else if (fall && read_r && cnt_r >= pdb_pkg::CNT_HEADER &&
                  cnt_r < pdb_pkg::CNT_FRAME)
         begin
            sdo_r   <= shout_r[pdb_pkg::DATA_W-1];
            shout_r <= {shout_r[pdb_pkg::DATA_W-2:0], 1'b0};
            oe_n_r  <= 1'b0;
         end
      end

   assign rd_addr       = addr_r;
   assign wr            = wr_r;
   assign spi_sdio_o    = sdo_r;
   assign spi_sdio_oe_n = oe_n_r;

endmodule : pdb_spi_port
`default_nettype wire

// [logic/pdb_config_bank.sv]
// divider and bypass configuration register bank behind the serial port
//
// Notes on behaviour
// - prescale ratio is 9-bit binary, writes below 8 refused, resets to 24
// - reference pre-divider is 6-bit binary 1..63, zero means bypass, resets 0
// - doubler select 0 divides the bypass mux output, 1 doubles it; resets 0
// - while doubler select is 1 the pre-divider setting has no effect
// - oscillator choice resets to 0; 1 is reserved and never taken
// - feedback extension 0 uses divider a alone, 1 uses a times b
// - jitter loop bypass 0 keeps first loop running, 1 bypasses it
// - tuning polarity resets to 0, positive oscillator tuning slope
// - tuning polarity 1 selects negative oscillator tuning slope
// - force mid tuning resets to 1; software clears it to let loop lock
`default_nettype none
module pdb_config_bank
(
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       spi_sclk,
   input  wire logic       spi_cs_n,
   input  wire logic       spi_sdio_i,
   output logic            spi_sdio_o,
   output logic            spi_sdio_oe_n,
   output pdb_pkg::pdb_cfg_t cfg
);

   pdb_pkg::pdb_wr_t              wr;
   logic [pdb_pkg::ADDR_W-1:0]    rd_addr;
   logic [pdb_pkg::DATA_W-1:0]    rd_data;

   logic [pdb_pkg::DATA_W-1:0]    feedback_ext_r;
   logic [pdb_pkg::DATA_W-1:0]    loop_bypass_r;
   logic [pdb_pkg::DATA_W-1:0]    polarity_pump_r;
   logic [pdb_pkg::DATA_W-1:0]    osc_offset_r;
   logic [pdb_pkg::DATA_W-1:0]    osc_amp_pump_r;
   logic [8:0]                    prescale_r;
   logic [pdb_pkg::DATA_W-1:0]    second_stage_r;
   logic [8:0]                    prescale_nxt;
   logic [pdb_pkg::DATA_W-1:0]    second_stage_nxt;
   pdb_pkg::pdb_cfg_t             cfg_r;
   pdb_pkg::pdb_cfg_t             cfg_nxt;

   function automatic logic hit
   (
      input pdb_pkg::pdb_wr_t          w,
      input logic [pdb_pkg::ADDR_W-1:0] a
   );
      hit = w.valid && w.addr == a;
   endfunction : hit

   function automatic logic [pdb_pkg::DATA_W-1:0] masked
   (
      input logic [pdb_pkg::DATA_W-1:0] d,
      input logic [pdb_pkg::DATA_W-1:0] m
   );
      masked = d & m;
   endfunction : masked

   function automatic logic ratio_ok
   (
      input logic [8:0] r
   );
      ratio_ok = r >= pdb_pkg::PRESCALE_MIN;
   endfunction : ratio_ok

   pdb_spi_port u_port
   (
      .clk_sys       (clk_sys),
      .rst           (rst),
      .spi_sclk      (spi_sclk),
      .spi_cs_n      (spi_cs_n),
      .spi_sdio_i    (spi_sdio_i),
      .spi_sdio_o    (spi_sdio_o),
      .spi_sdio_oe_n (spi_sdio_oe_n),
      .rd_addr       (rd_addr),
      .rd_data       (rd_data),
      .wr            (wr)
   );

   // first loop feedback and bypass controls
   always_ff @(posedge clk_sys or posedge rst)
      if (rst)
      begin
         feedback_ext_r <= pdb_pkg::RST_FEEDBACK_EXT;
         loop_bypass_r  <= pdb_pkg::RST_LOOP_BYPASS;
      end
      else
      begin
         if (hit(wr, pdb_pkg::ADDR_FEEDBACK_EXT))
            feedback_ext_r <= masked(wr.data,
                                     pdb_pkg::MASK_FEEDBACK_EXT);
         if (hit(wr, pdb_pkg::ADDR_LOOP_BYPASS))
            loop_bypass_r <= masked(wr.data,
                                    pdb_pkg::MASK_LOOP_BYPASS);
      end

   // polarity, forced mid tuning, oscillator output and pump currents
   always_ff @(posedge clk_sys or posedge rst)
      if (rst)
      begin
         polarity_pump_r <= pdb_pkg::RST_POLARITY_PUMP;
         osc_offset_r    <= pdb_pkg::RST_OSC_OFFSET;
         osc_amp_pump_r  <= pdb_pkg::RST_OSC_AMP_PUMP;
      end
      else
      begin
         if (hit(wr, pdb_pkg::ADDR_POLARITY_PUMP))
            polarity_pump_r <= masked(wr.data,
                                      pdb_pkg::MASK_POLARITY_PUMP);
         if (hit(wr, pdb_pkg::ADDR_OSC_OFFSET))
            osc_offset_r <= masked(wr.data, pdb_pkg::MASK_OSC_OFFSET);
         if (hit(wr, pdb_pkg::ADDR_OSC_AMP_PUMP))
            osc_amp_pump_r <= masked(wr.data,
                                     pdb_pkg::MASK_OSC_AMP_PUMP);
      end

   // the ratio spans two addresses; each half is checked against the
   // other stored half, so software writes the high half first
   always_comb
   begin
      prescale_nxt = prescale_r;
      if (hit(wr, pdb_pkg::ADDR_PRESCALE_LO))
         prescale_nxt = {prescale_r[8], wr.data};
      else if (hit(wr, pdb_pkg::ADDR_PRESCALE_HI))
         prescale_nxt = {wr.data[pdb_pkg::PRESCALE_HI_POS],
                         prescale_r[7:0]};
   end

   always_ff @(posedge clk_sys or posedge rst)
      if (rst)
         prescale_r <= pdb_pkg::RST_PRESCALE;
      else if (ratio_ok(prescale_nxt))
         prescale_r <= prescale_nxt;

   // oscillator choice 1 is reserved, so that bit is never stored
   always_comb
   begin
      second_stage_nxt = masked(wr.data, pdb_pkg::MASK_SECOND_STAGE);
      second_stage_nxt[pdb_pkg::OSC_CHOICE_POS] = 1'b0;
   end

   always_ff @(posedge clk_sys or posedge rst)
      if (rst)
         second_stage_r <= pdb_pkg::RST_SECOND_STAGE;
      else if (hit(wr, pdb_pkg::ADDR_SECOND_STAGE))
         second_stage_r <= second_stage_nxt;

   // read mux; unmapped addresses and reserved bits read as zero
   always_comb
   begin
      case (rd_addr)
         pdb_pkg::ADDR_FEEDBACK_EXT:
            rd_data = feedback_ext_r;
         pdb_pkg::ADDR_LOOP_BYPASS:
            rd_data = loop_bypass_r;
         pdb_pkg::ADDR_POLARITY_PUMP:
            rd_data = polarity_pump_r;
         pdb_pkg::ADDR_OSC_OFFSET:
            rd_data = osc_offset_r;
         pdb_pkg::ADDR_OSC_AMP_PUMP:
            rd_data = osc_amp_pump_r;
         pdb_pkg::ADDR_PRESCALE_LO:
            rd_data = prescale_r[7:0];
         pdb_pkg::ADDR_PRESCALE_HI:
            rd_data = {7'h00, prescale_r[8]};
         pdb_pkg::ADDR_SECOND_STAGE:
            rd_data = second_stage_r;
         default:
            rd_data = 8'h00;
      endcase
   end

   // settings presented to the analog side
   always_comb
   begin
      cfg_nxt = '0;
      cfg_nxt.prescale_ratio = prescale_r;
      cfg_nxt.doubler_select =
         second_stage_r[pdb_pkg::DOUBLER_POS];
      // with the doubler chosen the pre-divider is not in the path
      if (cfg_nxt.doubler_select)
      begin
         cfg_nxt.reference_prediv = pdb_pkg::PREDIV_BYPASS;
         cfg_nxt.prediv_bypassed  = 1'b1;
      end
      else
      begin
         cfg_nxt.reference_prediv =
            second_stage_r[pdb_pkg::PREDIV_MSB:pdb_pkg::PREDIV_LSB];
         cfg_nxt.prediv_bypassed =
            cfg_nxt.reference_prediv == pdb_pkg::PREDIV_BYPASS;
      end
      cfg_nxt.oscillator_choice =
         second_stage_r[pdb_pkg::OSC_CHOICE_POS];
      cfg_nxt.feedback_extension =
         feedback_ext_r[pdb_pkg::FEEDBACK_EXT_POS];
      cfg_nxt.feedback_div_b_msb =
         feedback_ext_r[pdb_pkg::FEEDBACK_B8_POS];
      cfg_nxt.jitter_loop_bypass =
         loop_bypass_r[pdb_pkg::LOOP_BYPASS_POS];
      cfg_nxt.tuning_polarity =
         polarity_pump_r[pdb_pkg::POLARITY_POS];
      cfg_nxt.force_mid_tuning =
         polarity_pump_r[pdb_pkg::FORCE_MID_POS];
      cfg_nxt.first_loop_pump_current =
         polarity_pump_r[pdb_pkg::PUMP_MSB:pdb_pkg::PUMP_LSB];
      cfg_nxt.osc_output_power =
         osc_offset_r[pdb_pkg::OSC_POWER_POS];
      cfg_nxt.osc_output_format =
         osc_offset_r[pdb_pkg::OSC_FORMAT_POS];
      cfg_nxt.phase_offset_enable =
         osc_offset_r[pdb_pkg::OFFSET_EN_POS];
      cfg_nxt.phase_offset =
         osc_offset_r[pdb_pkg::PUMP_MSB:pdb_pkg::PUMP_LSB];
      cfg_nxt.osc_output_amplitude =
         osc_amp_pump_r[pdb_pkg::AMP_MSB:pdb_pkg::AMP_LSB];
      cfg_nxt.second_loop_pump_current =
         osc_amp_pump_r[pdb_pkg::PUMP_MSB:pdb_pkg::PUMP_LSB];
   end

   // registered copy keeps the analog controls glitch free
   always_ff @(posedge clk_sys or posedge rst)
      if (rst)
      begin
         cfg_r                         <= '0;
         cfg_r.prescale_ratio          <= pdb_pkg::RST_PRESCALE;
         cfg_r.prediv_bypassed         <= 1'b1;
         cfg_r.force_mid_tuning        <= 1'b1;
         cfg_r.first_loop_pump_current <=
            pdb_pkg::RST_POLARITY_PUMP[pdb_pkg::PUMP_MSB:pdb_pkg::PUMP_LSB];
      end
      else
         cfg_r <= cfg_nxt;

   assign cfg = cfg_r;

endmodule : pdb_config_bank
`default_nettype wire

// [bench/pdb_config_bank_asserts.sv]
// assertion checker for the divider and bypass config bank
`default_nettype none
module pdb_config_bank_asserts
(
   input wire logic              clk_sys,
   input wire logic              rst,
   input wire logic              spi_sclk,
   input wire logic              spi_cs_n,
   input wire logic              spi_sdio_i,
   input wire logic              spi_sdio_o,
   input wire logic              spi_sdio_oe_n,
   input wire pdb_pkg::pdb_cfg_t cfg
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   AST_RST_PRESCALE: assert property
      ($fell(rst) |-> cfg.prescale_ratio == 9'h018)
      else $error("prescale ratio not 24 after reset");
   AST_PRESCALE_MIN: assert property
      (cfg.prescale_ratio >= 9'h008)
      else $error("prescale ratio below 8");
   AST_RST_PREDIV: assert property
      ($fell(rst) |-> cfg.reference_prediv == 6'h00 && cfg.prediv_bypassed)
      else $error("pre-divider not bypassed after reset");
   AST_BYPASS_CODE: assert property
      (cfg.prediv_bypassed == (cfg.reference_prediv == 6'h00))
      else $error("bypass flag disagrees with pre-divider code");
   AST_RST_DOUBLER: assert property
      ($fell(rst) |-> !cfg.doubler_select)
      else $error("doubler select not 0 after reset");
   AST_DOUBLER_IGNORES: assert property
      (cfg.doubler_select |-> cfg.reference_prediv == 6'h00
       && cfg.prediv_bypassed)
      else $error("pre-divider active while doubler selected");
   AST_OSC_CHOICE: assert property
      (!cfg.oscillator_choice)
      else $error("reserved oscillator choice taken");
   AST_RST_LOOP: assert property
      ($fell(rst) |-> !cfg.feedback_extension && !cfg.jitter_loop_bypass)
      else $error("loop control bits not 0 after reset");
   AST_RST_TUNING: assert property
      ($fell(rst) |-> !cfg.tuning_polarity && cfg.force_mid_tuning)
      else $error("tuning bits wrong after reset");
   // a quiet port must never disturb stored settings
   AST_IDLE_STABLE: assert property
      (spi_cs_n [*8] |-> $stable(cfg))
      else $error("config changed with no frame");
   // two sync stages plus the output flop before sdio is let go
   AST_OE_RELEASE: assert property
      (spi_cs_n [*4] |-> spi_sdio_oe_n)
      else $error("sdio still driven after frame end");

   cover property (cfg.doubler_select);
   cover property (cfg.tuning_polarity);
   cover property ($fell(cfg.force_mid_tuning));
endmodule : pdb_config_bank_asserts

bind pdb_config_bank pdb_config_bank_asserts u_asserts
(
   .clk_sys       (clk_sys),
   .rst           (rst),
   .spi_sclk      (spi_sclk),
   .spi_cs_n      (spi_cs_n),
   .spi_sdio_i    (spi_sdio_i),
   .spi_sdio_o    (spi_sdio_o),
   .spi_sdio_oe_n (spi_sdio_oe_n),
   .cfg           (cfg)
);
`default_nettype wire

// [bench/pdb_config_bank_tb.sv]
// self-checking bench for the divider and bypass config bank
`default_nettype none
module pdb_config_bank_tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic              clk_sys;
   logic              rst;
   logic              spi_sclk;
   logic              spi_cs_n;
   logic              spi_sdio_i;
   logic              spi_sdio_o;
   logic              spi_sdio_oe_n;
   pdb_pkg::pdb_cfg_t cfg;
   int                n_mismatch;
   int                comparisons;

   pdb_config_bank dut
   (
      .clk_sys       (clk_sys),
      .rst           (rst),
      .spi_sclk      (spi_sclk),
      .spi_cs_n      (spi_cs_n),
      .spi_sdio_i    (spi_sdio_i),
      .spi_sdio_o    (spi_sdio_o),
      .spi_sdio_oe_n (spi_sdio_oe_n),
      .cfg           (cfg)
   );

   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // sclk phases of 5 cycles keep clear of the 4-cycle oversampling floor
   task automatic xfer(input logic rw, input logic [6:0] a,
                       input logic [7:0] d, output logic [7:0] q);
      logic [15:0] f;
      f = {rw, a, d};
      q = 8'h00;
      spi_cs_n = 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         // released line toggles so a stale bit cannot pass as read data
         spi_sdio_i = (rw && i < 8) ? ~spi_sdio_i : f[i];
         tick(5);
         if (rw && i < 8)
            q[i] = spi_sdio_o;
         if (i == 0)
            check("oe_n", 16'(spi_sdio_oe_n), 16'(!rw));
         spi_sclk = 1'b1;
         tick(5);
         spi_sclk = 1'b0;
      end
      tick(5);
      spi_cs_n = 1'b1;
      tick(8);
   endtask : xfer

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] q;
      xfer(1'b0, a, d, q);
   endtask : wr

   task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] q;
      xfer(1'b1, a, 8'h00, q);
      check($sformatf("reg %h", a), 16'(q), 16'(exp));
      // sdio must be released once the frame has ended
      check("oe_n_rel", 16'(spi_sdio_oe_n), 16'h0001);
   endtask : rdchk

   task automatic do_reset();
      rst = 1'b1;
      tick(6);
      rst = 1'b0;
      tick(4);
   endtask : do_reset

   task automatic t_reset();
      check("prescale", 16'(cfg.prescale_ratio), 16'h0018);
      check("prediv", 16'(cfg.reference_prediv), 16'h0000);
      check("bypassed", 16'(cfg.prediv_bypassed), 16'h0001);
      check("doubler", 16'(cfg.doubler_select), 16'h0000);
      check("osc", 16'(cfg.oscillator_choice), 16'h0000);
      check("fb_ext", 16'(cfg.feedback_extension), 16'h0000);
      check("loop_byp", 16'(cfg.jitter_loop_bypass), 16'h0000);
      check("polarity", 16'(cfg.tuning_polarity), 16'h0000);
      check("force_mid", 16'(cfg.force_mid_tuning), 16'h0001);
      rdchk(7'h03, 8'h00);
      rdchk(7'h0a, 8'h00);
      rdchk(7'h10, 8'h58);
      rdchk(7'h11, 8'h00);
      rdchk(7'h12, 8'h00);
      rdchk(7'h20, 8'h18);
      rdchk(7'h21, 8'h00);
      rdchk(7'h22, 8'h00);
   endtask : t_reset

   task automatic t_loop_bits();
      logic [6:0] ad [5];
      logic [7:0] ex [5];
      ad = '{7'h03, 7'h0a, 7'h10, 7'h11, 7'h12};
      ex = '{8'h81, 8'h01, 8'hdf, 8'hff, 8'h7f};
      for (int i = 0; i < 5; i++)
      begin
         wr(ad[i], 8'hff);
         rdchk(ad[i], ex[i]);
      end
      check("fb_div_b", 16'(cfg.feedback_div_b_msb), 16'h0001);
      check("force_mid", 16'(cfg.force_mid_tuning), 16'h0001);
      check("pump_a", 16'(cfg.first_loop_pump_current), 16'h001f);
      check("amp", 16'(cfg.osc_output_amplitude), 16'h0003);
      check("pump_b", 16'(cfg.second_loop_pump_current), 16'h001f);
      check("osc_out", 16'({cfg.osc_output_power, cfg.osc_output_format,
                            cfg.phase_offset_enable, cfg.phase_offset}),
            16'h00ff);
      check("fb_ext", 16'(cfg.feedback_extension), 16'h0001);
      check("loop_byp", 16'(cfg.jitter_loop_bypass), 16'h0001);
      check("polarity", 16'(cfg.tuning_polarity), 16'h0001);
      wr(7'h10, 8'h00);
      wr(7'h03, 8'h00);
      wr(7'h0a, 8'h00);
      check("force_mid", 16'(cfg.force_mid_tuning), 16'h0000);
      check("polarity", 16'(cfg.tuning_polarity), 16'h0000);
      check("fb_ext", 16'(cfg.feedback_extension), 16'h0000);
      check("loop_byp", 16'(cfg.jitter_loop_bypass), 16'h0000);
      wr(7'h05, 8'hff);
      rdchk(7'h05, 8'h00);
   endtask : t_loop_bits

   task automatic t_prescale();
      wr(7'h20, 8'h08);
      check("prescale", 16'(cfg.prescale_ratio), 16'h0008);
      wr(7'h20, 8'h07);
      check("prescale", 16'(cfg.prescale_ratio), 16'h0008);
      wr(7'h21, 8'h01);
      check("prescale", 16'(cfg.prescale_ratio), 16'h0108);
      wr(7'h20, 8'hff);
      check("prescale", 16'(cfg.prescale_ratio), 16'h01ff);
      rdchk(7'h21, 8'h01);
      wr(7'h21, 8'h00);
      check("prescale", 16'(cfg.prescale_ratio), 16'h00ff);
   endtask : t_prescale

   task automatic t_prediv();
      wr(7'h22, 8'h3f);
      check("prediv", 16'(cfg.reference_prediv), 16'h003f);
      check("bypassed", 16'(cfg.prediv_bypassed), 16'h0000);
      wr(7'h22, 8'h85);
      check("osc", 16'(cfg.oscillator_choice), 16'h0000);
      rdchk(7'h22, 8'h05);
      wr(7'h22, 8'h45);
      check("doubler", 16'(cfg.doubler_select), 16'h0001);
      check("prediv", 16'(cfg.reference_prediv), 16'h0000);
      check("bypassed", 16'(cfg.prediv_bypassed), 16'h0001);
      wr(7'h22, 8'h00);
      check("doubler", 16'(cfg.doubler_select), 16'h0000);
      check("bypassed", 16'(cfg.prediv_bypassed), 16'h0001);
   endtask : t_prediv

   task automatic conclude();
      if (n_mismatch == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : conclude

   initial
   begin
      n_mismatch = 0;
      comparisons = 0;
      rst = 1'b1;
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_sdio_i = 1'b0;
      do_reset();
      t_reset();
      t_loop_bits();
      t_prescale();
      t_prediv();
      // second reset mid-run must restore every default
      do_reset();
      t_reset();
      conclude();
   end
endmodule : pdb_config_bank_tb
`default_nettype wire
